// ### bench/als_checker.sv
// checker for the sensitivity control block
// assumes it is bound onto als_sens_ctrl and sees only its ports
module als_checker (
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  // register bus
  input wire logic [9:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  // interrupt pin
  input wire logic        INT_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  logic [16:0] up_ff;
  logic [7:0]  trim_ff;
  logic        run_ff;
  logic        ien_ff;
  logic        wr_ok;
  logic        rd_ok;
  logic [7:0]  idx;
  assign idx   = AVS_ADDRESS[9:2];
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  assign rd_ok = AVS_READ && !AVS_WAITREQUEST;
  // shadow trim only tracks writes made while powered down
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      up_ff   <= 17'h0;
      trim_ff <= als_pkg::TRIM_RESET;
      run_ff  <= 1'b0;
      ien_ff  <= 1'b0;
    end else begin
      if (up_ff != 17'd100000) up_ff <= up_ff + 17'h1;
      if (wr_ok && idx == als_pkg::IDX_CTRL) begin
        run_ff <= AVS_WRITEDATA[0];
        ien_ff <= AVS_WRITEDATA[2];
      end
      if (wr_ok && idx == als_pkg::IDX_TRIM && !run_ff
          && AVS_WRITEDATA[7:0] >= als_pkg::TRIM_MIN
          && AVS_WRITEDATA[7:0] <= als_pkg::TRIM_MAX) trim_ff <= AVS_WRITEDATA[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_wait_reset: assert property (disable iff (1'b0) RESET |=> AVS_WAITREQUEST)
    else $error("waitrequest low after reset");
  a_rdata_reset: assert property (disable iff (1'b0) RESET |=> AVS_READDATA == 32'h0)
    else $error("read data not cleared by reset");
  a_int_reset: assert property (disable iff (1'b0) RESET |=> !INT_OE)
    else $error("interrupt pin driven after reset");
  a_powerup_hold: assert property (up_ff < 17'd99990 |-> AVS_WAITREQUEST)
    else $error("access answered before power-up");
  a_ack_bound: assert property (up_ff == 17'd100000 && (AVS_READ || AVS_WRITE)
    && AVS_WAITREQUEST |-> ##[1:4] !AVS_WAITREQUEST)
    else $error("access not answered");
  a_ack_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low twice");
  a_trim_read: assert property (rd_ok && idx == als_pkg::IDX_TRIM
    |-> AVS_READDATA == {24'h0, trim_ff})
    else $error("trim readback wrong");
  a_result_width: assert property (rd_ok && idx[7:1] == 7'h26
    |-> AVS_READDATA[31:8] == 24'h0)
    else $error("result byte too wide");
  a_int_idle: assert property (!ien_ff |-> !INT_OE)
    else $error("interrupt pin driven while disabled");
  c_trim_rd: cover property (rd_ok && idx == als_pkg::IDX_TRIM);
  c_data_hi: cover property (rd_ok && idx == als_pkg::IDX_DATA_HI);
  c_run_wr: cover property (wr_ok && idx == als_pkg::IDX_CTRL);
endmodule
bind als_sens_ctrl als_checker chk (.CLK_SYS(CLK_SYS), .RESET(RESET),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .INT_OE(INT_OE));

// ### bench/als_host.sv
// host controller model: avalon-mm master of the register port
// assumes one access at a time, answered by waitrequest low
module als_host (
  // clock
  input wire logic    clk,
  // bus
  output logic [9:0]  address,
  output logic        read,
  output logic        write,
  output logic [31:0] writedata,
  output logic [3:0]  byteenable,
  input wire logic    waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    address    = 10'h0;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h0;
    byteenable = 4'h0;
  end
  task automatic xfer(input logic rd, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    address    <= {idx, 2'b00};
    read       <= rd;
    write      <= !rd;
    writedata  <= {24'h0, d};
    byteenable <= 4'hf;
    @(posedge clk);
    while (waitrequest) @(posedge clk);
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  // no access until the device is operational
  task automatic power_up();
    repeat (als_pkg::POWER_UP_CYCLES + 2) @(posedge clk);
  endtask
  // power down and let the longest integration finish first
  task automatic set_trim(input logic [7:0] t);
    xfer(1'b0, als_pkg::IDX_CTRL, 8'h00);
    repeat (16 * 255) @(posedge clk);
    xfer(1'b0, als_pkg::IDX_TRIM, t);
  endtask
endmodule

// ### bench/testbench.sv
// self-checking bench for the sensitivity control block
// assumes a steady light input so counts follow the trim exactly
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys;
  logic        reset;
  logic        light;
  logic [9:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        int_oe;
  logic [7:0]  exp_q[$];
  logic [7:0]  bad;
  int          mismatches;
  int          compares;
  int          cycles;
  integer      seed;
  always #10 clk_sys = ~clk_sys;
  als_sens_ctrl DUT (.CLK_SYS(clk_sys), .RESET(reset), .AVS_ADDRESS(address),
    .AVS_READ(read), .AVS_WRITE(write), .AVS_WRITEDATA(writedata),
    .AVS_BYTEENABLE(byteenable), .AVS_READDATA(readdata),
    .AVS_WAITREQUEST(waitrequest), .LIGHT_PULSE(light), .INT_OUT(), .INT_OE(int_oe));
  als_host host (.clk(clk_sys), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b1, idx, 8'h00);
  endtask
  // read data is taken at the same edge that sees waitrequest low
  always @(posedge clk_sys) begin
    cycles++;
    if (read && !waitrequest && exp_q.size() > 0)
      check(readdata, {24'h0, exp_q.pop_front()});
    if (cycles > 125000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    light = 1'b1;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    seed = 32'h637ea53f;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    host.power_up();
    rd(als_pkg::IDX_STATUS, 8'h01);
    rd(als_pkg::IDX_TRIM, als_pkg::TRIM_RESET);
    rd(8'h7f, 8'h00);
    host.xfer(1'b0, 8'h7f, 8'haa);
    bad = 8'($unsigned($random(seed)) % 24);
    host.xfer(1'b0, als_pkg::IDX_TRIM, bad);
    host.xfer(1'b0, als_pkg::IDX_TRIM, 8'hff);
    rd(als_pkg::IDX_TRIM, als_pkg::TRIM_RESET);
    rd(als_pkg::IDX_STATUS, 8'h09);
    host.xfer(1'b0, als_pkg::IDX_STATUS, 8'h08);
    rd(als_pkg::IDX_STATUS, 8'h01);
    // doubling the trim must double the count of a steady light
    for (int i = 1; i <= 2; i++) begin
      host.set_trim(8'(24 * i));
      rd(als_pkg::IDX_TRIM, 8'(24 * i));
      host.xfer(1'b0, als_pkg::IDX_CTRL, 8'h01);
      host.xfer(1'b0, als_pkg::IDX_TRIM, 8'hfe);
      rd(als_pkg::IDX_TRIM, 8'(24 * i));
      repeat (24 * i * 32 + 40) @(posedge clk_sys);
      rd(als_pkg::IDX_DATA_LO, 8'(24 * i * 16));
      rd(als_pkg::IDX_DATA_HI, 8'((24 * i * 16) >> 8));
    end
    // stand-alone with a 2 ms interval: short integration then waits
    host.xfer(1'b0, als_pkg::IDX_RATE, als_pkg::RATE_RESET);
    host.xfer(1'b0, als_pkg::IDX_CTRL, 8'h03);
    repeat (48 * 16 * 2 + 40) @(posedge clk_sys);
    rd(als_pkg::IDX_STATUS, 8'h05);
    results();
  end
endmodule

// ### verilog/als_integrator.sv
// integration counter: counts light pulses for trim * unit cycles
// assumes the light input is already synchronised to the clock
module als_integrator #(
  parameter int UNIT = 16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [7:0]  trim,
  input  wire logic        light,
  output logic             done,
  output logic [15:0]      count
);

  typedef struct packed {
    logic        active;
    logic [7:0]  trim;
    logic [7:0]  units;
    logic [4:0]  sub;
    logic [15:0] acc;
    logic        done;
    logic [15:0] count;
  } integ_t;

  integ_t s_ff;
  integ_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (start && !s_ff.active) begin
      // trim is latched here so it holds for the whole measurement
      nxt_s.active = 1'b1;
      nxt_s.trim   = trim;
      nxt_s.units  = 8'h00;
      nxt_s.sub    = 5'h00;
      nxt_s.acc    = 16'h0000;
    end else if (s_ff.active) begin
      if (light && s_ff.acc != 16'hffff) begin
        nxt_s.acc = s_ff.acc + 16'h0001;
      end
      if (s_ff.sub == 5'(UNIT - 1)) begin
        nxt_s.sub   = 5'h00;
        nxt_s.units = s_ff.units + 8'h01;
        if (s_ff.units + 8'h01 == s_ff.trim) begin // RQ1
          nxt_s.active = 1'b0;
          nxt_s.done   = 1'b1;
          nxt_s.count  = nxt_s.acc;
        end
      end else begin
        nxt_s.sub = s_ff.sub + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign done  = s_ff.done;
  assign count = s_ff.count;

endmodule

// ### verilog/als_pkg.sv
// package for the ambient light sensitivity control block
// assumes a 50 MHz system clock and an avalon-mm register slave
package als_pkg;

  // register word offsets (byte address = 4 * index)
  localparam logic [7:0] IDX_TRIM     = 8'h5a;
  localparam logic [7:0] IDX_DATA_LO  = 8'h4c;
  localparam logic [7:0] IDX_DATA_HI  = 8'h4d;
  localparam logic [7:0] IDX_CTRL     = 8'h40;
  localparam logic [7:0] IDX_RATE     = 8'h45;
  localparam logic [7:0] IDX_STATUS   = 8'h4e;

  // reset values and trim limits
  localparam logic [7:0] TRIM_RESET   = 8'h35;
  localparam logic [7:0] TRIM_MIN     = 8'h18;
  localparam logic [7:0] TRIM_MAX     = 8'hfe;
  localparam logic [7:0] RATE_RESET   = 8'h02;

  // ctrl field positions
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_ALONE_BIT = 1;
  localparam int CTRL_INTEN_BIT = 2;

  // status field positions
  localparam int ST_READY_BIT   = 0;
  localparam int ST_BUSY_BIT    = 1;
  localparam int ST_VALID_BIT   = 2;
  localparam int ST_RANGE_BIT   = 3;

  // timing
  localparam int CLK_MHZ          = 50;
  localparam int POWER_UP_US      = 2000;
  localparam int POWER_UP_CYCLES  = POWER_UP_US * CLK_MHZ;
  localparam int TICK_US          = 1000;
  localparam int TICK_CYCLES      = TICK_US * CLK_MHZ;
  // base integration per trim unit, in system clock cycles
  localparam int UNIT_CYCLES      = 16;
  localparam logic [7:0] INT_HIGH_THRESH = 8'h80;

  typedef enum logic [1:0] {
    MS_DOWN  = 2'b00,
    MS_INTEG = 2'b01,
    MS_WAIT  = 2'b11
  } meas_state_t;

  typedef struct packed {
    logic        run;
    logic        alone;
    logic        int_en;
  } ctrl_t;

endpackage

// ### verilog/als_sens_ctrl.sv
// ambient light sensitivity control with avalon-mm register slave
// assumes a pulse-density light input from the sensor front end
// Operation
// RQ1: integration time scales with trim value
// RQ2: trim range 24 to 254, default 53
// RQ3: lux per count equals 53 over trim
// RQ4: host writes trim only when powered down
// RQ5: long integration overrides repeat interval
// RQ6: reset returns all registers to defaults
// RQ7: operational two ms after power up
// RQ8: interrupt pin released after power up
// RQ9: result is 16 bits, low and high bytes
// RQ10: new trim applies from next started measurement
//
// Our own choice: the Avalon-MM slave port.
module als_sens_ctrl (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  // avalon-mm slave
  input  wire logic [9:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // sensor front end
  input  wire logic        LIGHT_PULSE,
  // interrupt pin, open drain
  output logic             INT_OUT,
  output logic             INT_OE
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [1:0]               sync;
    logic [7:0]               trim;
    logic [7:0]               rate;
    als_pkg::ctrl_t           ctrl;
    logic                     range_err;
    logic                     valid;
    logic [15:0]              result;
    logic [7:0]               hi_shadow;
    logic [23:0]              por_cnt;
    logic                     ready;
    als_pkg::meas_state_t     ms;
    logic [15:0]              tick_cnt;
    logic [7:0]               rate_cnt;
    logic                     start;
    logic                     int_drive;
    logic                     ack;
    logic [31:0]              rdata;
  } top_t;

  top_t s_ff;
  top_t nxt_s;

  logic        integ_done;
  logic [15:0] integ_count;
  logic [7:0]  word_idx;
  logic        acc_req;

  assign word_idx = AVS_ADDRESS[9:2];
  assign acc_req  = (AVS_READ || AVS_WRITE) && !s_ff.ack;

  ////////////////////////////////////////////////////////////////////////
  // integration engine

  als_integrator #(
    .UNIT (als_pkg::UNIT_CYCLES)
  ) u_integ (
    .clk   (CLK_SYS),
    .rst   (RESET),
    .start (s_ff.start),
    .trim  (s_ff.trim),
    .light (s_ff.sync[1]),
    .done  (integ_done),
    .count (integ_count)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_s = s_ff;
    nxt_s.sync  = {s_ff.sync[0], LIGHT_PULSE};
    nxt_s.start = 1'b0;
    nxt_s.ack   = 1'b0;

    // power-up delay before any access is served
    if (!s_ff.ready) begin
      if (s_ff.por_cnt == 24'(als_pkg::POWER_UP_CYCLES - 1)) begin // RQ7
        nxt_s.ready = 1'b1;
      end else begin
        nxt_s.por_cnt = s_ff.por_cnt + 24'h000001;
      end
    end

    // repeat interval ticks in milliseconds
    if (s_ff.tick_cnt == 16'(als_pkg::TICK_CYCLES - 1)) begin
      nxt_s.tick_cnt = 16'h0000;
      // interval runs from each start, so a long integration can use it up
      if (s_ff.ms != als_pkg::MS_DOWN && s_ff.rate_cnt != 8'h00) begin // RQ5
        nxt_s.rate_cnt = s_ff.rate_cnt - 8'h01;
      end
    end else begin
      nxt_s.tick_cnt = s_ff.tick_cnt + 16'h0001;
    end

    unique case (s_ff.ms)
      als_pkg::MS_DOWN: begin
        if (s_ff.ctrl.run && s_ff.ready) begin
          nxt_s.ms       = als_pkg::MS_INTEG;
          nxt_s.start    = 1'b1; // RQ10
          nxt_s.rate_cnt = s_ff.rate;
        end
      end
      als_pkg::MS_INTEG: begin
        if (integ_done) begin
          // raw count: lux = count * 53 / trim, scaling left to software
          nxt_s.result = integ_count; // RQ3 RQ9
          nxt_s.valid  = 1'b1;
          if (!s_ff.ctrl.run) begin
            nxt_s.ms = als_pkg::MS_DOWN;
          end else if (s_ff.ctrl.alone && s_ff.rate_cnt != 8'h00) begin
            nxt_s.ms = als_pkg::MS_WAIT;
          end else begin
            // continuous mode, or interval already spent during integration: restart at once
            nxt_s.start    = 1'b1; // RQ5
            nxt_s.rate_cnt = s_ff.rate;
          end
        end
      end
      als_pkg::MS_WAIT: begin
        if (!s_ff.ctrl.run) begin
          nxt_s.ms = als_pkg::MS_DOWN;
        end else if (s_ff.rate_cnt == 8'h00) begin
          nxt_s.ms       = als_pkg::MS_INTEG;
          nxt_s.start    = 1'b1;
          nxt_s.rate_cnt = s_ff.rate;
        end
      end
      default: nxt_s.ms = als_pkg::MS_DOWN;
    endcase

    // open drain: pin released until logic pulls it low
    nxt_s.int_drive = s_ff.ctrl.int_en && s_ff.valid &&
                      s_ff.result[15:8] >= als_pkg::INT_HIGH_THRESH; // RQ8

    // register slave, one wait cycle per access
    if (acc_req && s_ff.ready) begin
      nxt_s.ack   = 1'b1;
      nxt_s.rdata = 32'h00000000;
      if (AVS_WRITE && AVS_BYTEENABLE[0]) begin
        unique case (word_idx)
          als_pkg::IDX_TRIM: begin
            // a write during measurement could corrupt it, so it is dropped
            if (s_ff.ms == als_pkg::MS_DOWN && !s_ff.ctrl.run) begin // RQ4
              if (AVS_WRITEDATA[7:0] < als_pkg::TRIM_MIN ||
                  AVS_WRITEDATA[7:0] > als_pkg::TRIM_MAX) begin // RQ2
                nxt_s.range_err = 1'b1;
              end else begin
                nxt_s.trim = AVS_WRITEDATA[7:0];
              end
            end
          end
          als_pkg::IDX_RATE: nxt_s.rate = AVS_WRITEDATA[7:0];
          als_pkg::IDX_CTRL: begin
            nxt_s.ctrl.run    = AVS_WRITEDATA[als_pkg::CTRL_RUN_BIT];
            nxt_s.ctrl.alone  = AVS_WRITEDATA[als_pkg::CTRL_ALONE_BIT];
            nxt_s.ctrl.int_en = AVS_WRITEDATA[als_pkg::CTRL_INTEN_BIT];
          end
          als_pkg::IDX_STATUS: begin
            if (AVS_WRITEDATA[als_pkg::ST_RANGE_BIT]) begin
              nxt_s.range_err = 1'b0;
            end
          end
          default: ;
        endcase
      end else if (AVS_READ) begin
        unique case (word_idx)
          als_pkg::IDX_TRIM:    nxt_s.rdata[7:0] = s_ff.trim;
          als_pkg::IDX_RATE:    nxt_s.rdata[7:0] = s_ff.rate;
          als_pkg::IDX_CTRL:    nxt_s.rdata[2:0] = {s_ff.ctrl.int_en, s_ff.ctrl.alone,
                                                    s_ff.ctrl.run};
          als_pkg::IDX_DATA_LO: begin
            // low byte read freezes the high byte so the pair stays coherent
            nxt_s.rdata[7:0] = s_ff.result[7:0]; // RQ9
            nxt_s.hi_shadow  = s_ff.result[15:8];
          end
          als_pkg::IDX_DATA_HI: nxt_s.rdata[7:0] = s_ff.hi_shadow; // RQ9
          als_pkg::IDX_STATUS: begin
            nxt_s.rdata[als_pkg::ST_READY_BIT] = s_ff.ready;
            nxt_s.rdata[als_pkg::ST_BUSY_BIT]  = (s_ff.ms == als_pkg::MS_INTEG);
            nxt_s.rdata[als_pkg::ST_VALID_BIT] = s_ff.valid;
            nxt_s.rdata[als_pkg::ST_RANGE_BIT] = s_ff.range_err;
          end
          default: nxt_s.rdata = 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s_ff           <= '0; // RQ6
      s_ff.trim      <= als_pkg::TRIM_RESET;
      s_ff.rate      <= als_pkg::RATE_RESET;
      s_ff.ms        <= als_pkg::MS_DOWN;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, straight from flip-flops except INT_OUT, which is tied low

  assign AVS_READDATA    = s_ff.rdata;
  assign AVS_WAITREQUEST = !s_ff.ack;
  assign INT_OUT         = 1'b0;
  assign INT_OE          = s_ff.int_drive;

endmodule
